// [dv/smb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smb_host_model #(
	parameter int HALF_NS = 2000
) (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	// ----------------------------------------------
	// bus master; released lines float high
	// ----------------------------------------------
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic start();
		sda_m = 1'b1;
		#HALF_NS scl = 1'b1;
		#HALF_NS sda_m = 1'b0;
		#HALF_NS scl = 1'b0;
	endtask
	task automatic stop();
		sda_m = 1'b0;
		#HALF_NS scl = 1'b1;
		#HALF_NS sda_m = 1'b1;
		#HALF_NS;
	endtask
	// data set in low phase, sampled mid high phase
	task automatic xbit(input logic b, output logic v);
		sda_m = b;
		#HALF_NS scl = 1'b1;
		#(HALF_NS / 2) v = sda;
		#(HALF_NS / 2) scl = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--)
			xbit(d[i], v);
		xbit(1'b1, ack);
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic v;
		for (int i = 7; i >= 0; i--)
			xbit(1'b1, d[i]);
		xbit(nack, v);
	endtask
	// a second sender on the wire during a read; no acknowledge after it
	task automatic cbyte(input logic [7:0] c, output logic [7:0] d);
		logic v;
		for (int i = 7; i >= 0; i--)
			xbit(c[i], d[i]);
		xbit(1'b1, v);
	endtask
endmodule
`default_nettype wire

// [dv/smb_slave_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module smb_slave_port_chk #(
	parameter int TIMEOUT_CYCLES = 200
) (
	input wire logic                  clk,
	input wire logic                  srst,
	input wire logic                  link_clk,
	input wire logic                  scl_i,
	input wire logic                  sda_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe_n,
	input wire logic                  alert_o,
	input wire logic                  alert_oe_n,
	input wire logic                  strap_address_enable,
	input wire logic                  strap_address_select,
	input wire logic                  bus_timeout_disable,
	input wire logic                  status_unmasked_pending,
	input wire smb_pkg::smb_reg_req_s reg_req,
	input wire logic [7:0]            reg_rd_data
);
	// ----------------------------------------------
	// stall counter: scl frozen while we pull sda
	// ----------------------------------------------
	logic [31:0] idle_cnt_q;
	logic        scl_q;
	always_ff @(posedge clk)
	begin
		scl_q <= scl_i;
		if (srst || bus_timeout_disable || sda_oe_n || scl_i != scl_q)
			idle_cnt_q <= 32'h0;
		else
			idle_cnt_q <= idle_cnt_q + 32'h1;
	end
	// ----------------------------------------------
	// properties
	// ----------------------------------------------
	a_alert_tracks: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> alert_oe_n == !$past(status_unmasked_pending))
		else $error("alert level does not follow pending status");
	a_alert_pulls: assert property (@(posedge clk) disable iff (srst) alert_o == 1'b0)
		else $error("alert pin drives high");
	a_sda_pulls: assert property (@(posedge clk) disable iff (srst) sda_o == 1'b0)
		else $error("sda pin drives high");
	a_sda_scl_low: assert property (@(posedge link_clk) disable iff (srst)
		$changed(sda_oe_n) |-> !scl_i)
		else $error("sda drive changed while scl high");
	a_wr_pulse: assert property (@(posedge clk) disable iff (srst)
		reg_req.wr_en |=> !reg_req.wr_en)
		else $error("write strobe longer than one cycle");
	a_rd_pulse: assert property (@(posedge clk) disable iff (srst)
		reg_req.rd_en |=> !reg_req.rd_en)
		else $error("read strobe longer than one cycle");
	a_rw_exclusive: assert property (@(posedge clk) disable iff (srst)
		!(reg_req.wr_en && reg_req.rd_en))
		else $error("read and write strobes together");
	a_ptr_steady: assert property (@(posedge clk) disable iff (srst)
		reg_req.rd_en |-> $stable(reg_req.ptr))
		else $error("pointer moved during read");
	a_stall_release: assert property (@(posedge clk) disable iff (srst)
		idle_cnt_q < TIMEOUT_CYCLES + 16)
		else $error("bus held past the stall limit");
endmodule
bind smb_slave_port smb_slave_port_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) smb_slave_port_chk_i (
	.clk(clk), .srst(srst), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_o(alert_o), .alert_oe_n(alert_oe_n),
	.strap_address_enable(strap_address_enable),
	.strap_address_select(strap_address_select),
	.bus_timeout_disable(bus_timeout_disable),
	.status_unmasked_pending(status_unmasked_pending),
	.reg_req(reg_req), .reg_rd_data(reg_rd_data));
`default_nettype wire

// [dv/smb_slave_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module smb_slave_port_tb;
	logic                  clk;
	logic                  srst;
	logic                  link_clk;
	logic                  scl;
	logic                  sda_m;
	wire logic             sda;
	logic                  sda_o;
	logic                  sda_oe_n;
	logic                  alert_o;
	logic                  alert_oe_n;
	logic                  strap_en;
	logic                  strap_sel;
	logic                  tmo_dis;
	logic                  pending;
	smb_pkg::smb_reg_req_s reg_req;
	logic [7:0]            reg_rd_data;
	logic [7:0]            regs [256];
	logic                  ack;
	logic [7:0]            rd;
	int                    mismatches = 0;
	int                    check_count = 0;
	int                    rd_pulses = 0;
	// ----------------------------------------------
	// clocks, wired-and bus, register file
	// ----------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = ~link_clk;
	end
	assign sda = sda_m & sda_oe_n;
	assign reg_rd_data = regs[reg_req.ptr];
	always @(posedge clk)
		if (reg_req.wr_en)
			regs[reg_req.ptr] <= reg_req.wdata;
	always @(posedge clk)
		if (reg_req.rd_en)
			rd_pulses++;
	smb_host_model smb_host_model_i (.scl(scl), .sda_m(sda_m), .sda(sda));
	smb_slave_port #(.TIMEOUT_CYCLES(200)) smb_slave_port_i (
		.clk(clk), .srst(srst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_o(alert_o), .alert_oe_n(alert_oe_n),
		.strap_address_enable(strap_en), .strap_address_select(strap_sel),
		.bus_timeout_disable(tmo_dis), .status_unmasked_pending(pending),
		.reg_req(reg_req), .reg_rd_data(reg_rd_data));
	// ----------------------------------------------
	// helpers
	// ----------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] b, input logic exp);
		smb_host_model_i.wbyte(b, ack);
		chk(8'(ack), 8'(exp));
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset();
		@(negedge clk) srst = 1'b1;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		repeat (20) @(negedge clk);
	endtask
	// ----------------------------------------------
	// scenarios
	// ----------------------------------------------
	task automatic t_write_byte();
		smb_host_model_i.start();
		wr(8'h5c, 1'b0);
		wr(8'h41, 1'b0);
		wr(8'ha5, 1'b0);
		wr(8'h77, 1'b1);
		smb_host_model_i.stop();
		chk(regs[8'h41], 8'ha5);
		chk(reg_req.ptr, 8'h41);
	endtask
	task automatic t_ptr_read();
		int n0;
		n0 = rd_pulses;
		smb_host_model_i.start();
		wr(8'h5c, 1'b0);
		wr(8'h10, 1'b0);
		smb_host_model_i.start();
		wr(8'h5d, 1'b0);
		smb_host_model_i.rbyte(1'b1, rd);
		chk(rd, 8'h3c);
		smb_host_model_i.stop();
		smb_host_model_i.start();
		wr(8'h5d, 1'b0);
		smb_host_model_i.rbyte(1'b1, rd);
		chk(rd, 8'h3c);
		smb_host_model_i.stop();
		chk(8'(rd_pulses - n0), 8'h02);
	endtask
	task automatic t_foreign();
		smb_host_model_i.start();
		wr(8'h5a, 1'b1);
		wr(8'h00, 1'b1);
		smb_host_model_i.stop();
		smb_host_model_i.start();
		wr(8'h19, 1'b1);
		smb_host_model_i.stop();
	endtask
	task automatic t_alert();
		@(negedge clk) pending = 1'b1;
		repeat (2) @(negedge clk);
		chk(8'(alert_oe_n), 8'h00);
		smb_host_model_i.start();
		wr(8'h19, 1'b0);
		smb_host_model_i.rbyte(1'b1, rd);
		chk(rd, 8'h5c);
		smb_host_model_i.stop();
		// lower address 0x2b wins at bit 3; device must go quiet after it
		smb_host_model_i.start();
		wr(8'h19, 1'b0);
		smb_host_model_i.cbyte(8'h56, rd);
		chk(rd, 8'h56);
		smb_host_model_i.stop();
		@(negedge clk) pending = 1'b0;
		repeat (2) @(negedge clk);
		chk(8'(alert_oe_n), 8'h01);
	endtask
	task automatic t_strap_latch();
		@(negedge clk);
		strap_en = 1'b0;
		strap_sel = 1'b0;
		smb_host_model_i.start();
		wr(8'h5c, 1'b0);
		smb_host_model_i.stop();
		smb_host_model_i.start();
		wr(8'h58, 1'b1);
		smb_host_model_i.stop();
	endtask
	// pointer holds 0x10, so the first read bit is a driven zero
	task automatic t_timeout();
		@(negedge clk) tmo_dis = 1'b1;
		smb_host_model_i.start();
		wr(8'h5d, 1'b0);
		#30000;
		chk(8'(sda_oe_n), 8'h00);
		smb_host_model_i.rbyte(1'b1, rd);
		chk(rd, 8'h3c);
		smb_host_model_i.stop();
		@(negedge clk) tmo_dis = 1'b0;
		smb_host_model_i.start();
		wr(8'h5d, 1'b0);
		#30000;
		chk(8'(sda_oe_n), 8'h01);
		smb_host_model_i.stop();
	endtask
	task automatic t_reset_strap();
		strap_sel = 1'b1;
		do_reset();
		smb_host_model_i.start();
		wr(8'h5a, 1'b0);
		smb_host_model_i.stop();
		smb_host_model_i.start();
		wr(8'h5c, 1'b1);
		smb_host_model_i.stop();
	endtask
	// ----------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------
	initial
	begin
		srst = 1'b1;
		strap_en = 1'b1;
		strap_sel = 1'b0;
		tmo_dis = 1'b0;
		pending = 1'b0;
		foreach (regs[i])
			regs[i] = 8'h00;
		regs[8'h10] = 8'h3c;
		do_reset();
		t_write_byte();
		t_ptr_read();
		t_foreign();
		t_alert();
		t_strap_latch();
		t_timeout();
		t_reset_strap();
		summarize();
	end
	initial
	begin
		#6000000;
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire

// [src/smb_pkg.sv]
package smb_pkg;

	// ----------------------------------------------------------------
	// bus addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_FIXED_HI  = 5'h0b;
	localparam logic [6:0] ADDR_DEFAULT   = 7'h2e;
	localparam logic [6:0] ADDR_ALERT_RSP = 7'h0c;
	localparam logic       DIR_WRITE      = 1'b0;
	localparam logic       DIR_READ       = 1'b1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PTR_RESET      = 8'h00;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [2:0] BIT_CNT_RESET  = 3'h0;
	localparam logic [1:0] BYTE_IDX_RESET = 2'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 10_000_000;
	localparam int TIMEOUT_MS  = 25;
	localparam int TIMEOUT_CYC = (TIMEOUT_MS * (CLK_HZ / 1000));

	// ----------------------------------------------------------------
	// link state machine
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LNK_IDLE,
		LNK_ADDR,
		LNK_ACK,
		LNK_RX,
		LNK_TX,
		LNK_TX_ACK,
		LNK_WAIT
	} smb_lnk_e;

	// ----------------------------------------------------------------
	// register access toward the register file
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] ptr;
		logic [7:0] wdata;
	} smb_reg_req_s;

endpackage

// [src/smb_slave_port.sv]
`timescale 1ns/1ps
`default_nettype none

module smb_slave_port #(
	parameter int TIMEOUT_CYCLES = smb_pkg::TIMEOUT_CYC
) (
	// core clock and reset
	input  wire logic                 clk,
	input  wire logic                 srst,
	// link sampling clock
	input  wire logic                 link_clk,
	// bus pins
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_n,
	output logic                      alert_o,
	output logic                      alert_oe_n,
	// address straps
	input  wire logic                 strap_address_enable,
	input  wire logic                 strap_address_select,
	// control and status
	input  wire logic                 bus_timeout_disable,
	input  wire logic                 status_unmasked_pending,
	// register file side
	output smb_pkg::smb_reg_req_s     reg_req,
	input  wire logic [7:0]           reg_rd_data
);

	// ----------------------------------------------------------------
	// link domain synchronisers
	// ----------------------------------------------------------------
	logic       lrst_m_q, lrst_q;
	logic [1:0] scl_m_q, sda_m_q;
	logic       scl_q, sda_q, scl_p_q, sda_p_q;
	logic [1:0] strap_m_q, strap_q;
	logic       alert_m_q, alert_s_q;
	logic       rd_ack_m_q, rd_ack_s_q, rd_ack_p_q;
	logic       abort_m_q, abort_s_q, abort_p_q;
	logic       rd_ack_tgl_q, abort_tgl_q;

	always_ff @(posedge link_clk)
	begin
		lrst_m_q <= srst;
		lrst_q   <= lrst_m_q;
	end

	always_ff @(posedge link_clk)
	begin
		scl_m_q    <= {scl_m_q[0], scl_i};
		sda_m_q    <= {sda_m_q[0], sda_i};
		scl_q      <= scl_m_q[1];
		sda_q      <= sda_m_q[1];
		scl_p_q    <= scl_q;
		sda_p_q    <= sda_q;
		strap_m_q  <= {strap_address_enable, strap_address_select};
		strap_q    <= strap_m_q;
		alert_m_q  <= ~alert_oe_n;
		alert_s_q  <= alert_m_q;
		rd_ack_m_q <= rd_ack_tgl_q;
		rd_ack_s_q <= rd_ack_m_q;
		rd_ack_p_q <= rd_ack_s_q;
		abort_m_q  <= abort_tgl_q;
		abort_s_q  <= abort_m_q;
		abort_p_q  <= abort_s_q;
	end

	// ----------------------------------------------------------------
	// bus conditions
	// ----------------------------------------------------------------
	logic start_ev, stop_ev, scl_rise, scl_fall;

	assign start_ev = scl_q & scl_p_q & sda_p_q & ~sda_q;
	assign stop_ev  = scl_q & scl_p_q & ~sda_p_q & sda_q;
	assign scl_rise = scl_q & ~scl_p_q;
	assign scl_fall = ~scl_q & scl_p_q;

	function automatic logic [6:0] strap_addr(input logic en, input logic sel);
		strap_addr = en ? smb_pkg::ADDR_DEFAULT : {smb_pkg::ADDR_FIXED_HI, 1'b0, sel};
	endfunction

	// ----------------------------------------------------------------
	// address selection and lock
	// ----------------------------------------------------------------
	logic       locked_q;
	logic [6:0] addr_q;
	logic [6:0] own_addr;
	logic [7:0] in_byte;
	logic       own_hit, ara_hit, byte_done;

	smb_pkg::smb_lnk_e st_q;
	logic [2:0] cnt_q;
	logic [7:0] sr_q;

	assign own_addr  = locked_q ? addr_q : strap_addr(strap_q[1], strap_q[0]);
	assign in_byte   = {sr_q[6:0], sda_q};
	assign byte_done = scl_rise & (cnt_q == 3'h7);
	assign own_hit   = (in_byte[7:1] == own_addr);
	// alert response is a read only, and only while this device alerts
	assign ara_hit   = (in_byte[7:1] == smb_pkg::ADDR_ALERT_RSP) & in_byte[0] & alert_s_q;

	always_ff @(posedge link_clk)
	begin
		if (lrst_q)
		begin
			locked_q <= 1'b0;
			addr_q   <= smb_pkg::ADDR_DEFAULT;
		end
		else if (!locked_q && st_q == smb_pkg::LNK_ADDR && byte_done && own_hit)
		begin
			locked_q <= 1'b1;
			addr_q   <= own_addr;
		end
	end

	// ----------------------------------------------------------------
	// link state machine
	// ----------------------------------------------------------------
	logic       drv_q, ack_on_q, rw_q, ara_q;
	logic [1:0] byte_idx_q;
	logic [7:0] tx_q, ptr_q, wdat_q;
	logic       wr_tgl_q, wr_is_data_q, rd_req_tgl_q, act_tgl_q, busy_q;
	logic [7:0] rd_data_hold_q;

	always_ff @(posedge link_clk)
	begin
		if (lrst_q)
		begin
			st_q         <= smb_pkg::LNK_IDLE;
			cnt_q        <= smb_pkg::BIT_CNT_RESET;
			sr_q         <= smb_pkg::BYTE_RESET;
			drv_q        <= 1'b0;
			ack_on_q     <= 1'b0;
			rw_q         <= smb_pkg::DIR_WRITE;
			ara_q        <= 1'b0;
			byte_idx_q   <= smb_pkg::BYTE_IDX_RESET;
			tx_q         <= smb_pkg::BYTE_RESET;
			ptr_q        <= smb_pkg::PTR_RESET;
			wdat_q       <= smb_pkg::BYTE_RESET;
			wr_tgl_q     <= 1'b0;
			wr_is_data_q <= 1'b0;
			rd_req_tgl_q <= 1'b0;
		end
		else if (abort_s_q != abort_p_q)
		begin
			st_q  <= smb_pkg::LNK_IDLE;
			drv_q <= 1'b0;
		end
		else if (start_ev)
		begin
			st_q     <= smb_pkg::LNK_ADDR;
			cnt_q    <= smb_pkg::BIT_CNT_RESET;
			drv_q    <= 1'b0;
			ack_on_q <= 1'b0;
		end
		else if (stop_ev)
		begin
			st_q  <= smb_pkg::LNK_IDLE;
			drv_q <= 1'b0;
		end
		else
		begin
			case (st_q)
				smb_pkg::LNK_ADDR:
				if (scl_rise)
				begin
					sr_q  <= in_byte;
					cnt_q <= cnt_q + 3'h1;
					if (byte_done)
					begin
						rw_q       <= in_byte[0];
						ara_q      <= ara_hit;
						byte_idx_q <= smb_pkg::BYTE_IDX_RESET;
						if (own_hit || ara_hit)
							st_q <= smb_pkg::LNK_ACK;
						else
							st_q <= smb_pkg::LNK_WAIT;
						if (own_hit && in_byte[0] == smb_pkg::DIR_READ)
							rd_req_tgl_q <= ~rd_req_tgl_q;
						if (ara_hit)
							tx_q <= {own_addr, 1'b0};
					end
				end
				smb_pkg::LNK_ACK:
				if (scl_fall)
				begin
					if (!ack_on_q)
					begin
						drv_q    <= 1'b1;
						ack_on_q <= 1'b1;
					end
					else
					begin
						ack_on_q <= 1'b0;
						cnt_q    <= smb_pkg::BIT_CNT_RESET;
						if (rw_q == smb_pkg::DIR_READ)
						begin
							st_q  <= smb_pkg::LNK_TX;
							drv_q <= ~tx_q[7];
						end
						else
						begin
							st_q  <= smb_pkg::LNK_RX;
							drv_q <= 1'b0;
						end
					end
				end
				smb_pkg::LNK_RX:
				if (scl_rise)
				begin
					sr_q  <= in_byte;
					cnt_q <= cnt_q + 3'h1;
					if (byte_done)
					begin
						byte_idx_q <= byte_idx_q + 2'h1;
						if (byte_idx_q == 2'h0)
						begin
							ptr_q        <= in_byte;
							wr_is_data_q <= 1'b0;
							wr_tgl_q     <= ~wr_tgl_q;
							st_q         <= smb_pkg::LNK_ACK;
						end
						else if (byte_idx_q == 2'h1)
						begin
							wdat_q       <= in_byte;
							wr_is_data_q <= 1'b1;
							wr_tgl_q     <= ~wr_tgl_q;
							st_q         <= smb_pkg::LNK_ACK;
						end
						else
							st_q <= smb_pkg::LNK_WAIT;
					end
				end
				smb_pkg::LNK_TX:
				begin
					if (scl_rise)
					begin
						cnt_q <= cnt_q + 3'h1;
						// released high but line low: another sender won
						if (!drv_q && !sda_q)
							st_q <= smb_pkg::LNK_WAIT;
					end
					else if (scl_fall)
					begin
						if (cnt_q == 3'h0)
						begin
							drv_q <= 1'b0;
							st_q  <= smb_pkg::LNK_TX_ACK;
						end
						else
						begin
							tx_q  <= {tx_q[6:0], 1'b0};
							drv_q <= ~tx_q[6];
						end
					end
				end
				smb_pkg::LNK_TX_ACK:
				if (scl_rise)
					st_q <= smb_pkg::LNK_WAIT;
				default:
				begin
					drv_q <= 1'b0;
				end
			endcase
			// read data arrives well before the ninth clock ends
			if (rd_ack_s_q != rd_ack_p_q && !ara_q)
				tx_q <= rd_data_hold_q;
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_n = ~drv_q;

	// activity and busy, for the inactivity watchdog
	always_ff @(posedge link_clk)
	begin
		if (lrst_q)
		begin
			act_tgl_q <= 1'b0;
			busy_q    <= 1'b0;
		end
		else
		begin
			if (scl_rise || scl_fall)
				act_tgl_q <= ~act_tgl_q;
			busy_q <= (st_q != smb_pkg::LNK_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// core domain: crossings in
	// ----------------------------------------------------------------
	logic wr_m_q, wr_s_q, wr_p_q;
	logic rd_m_q, rd_s_q, rd_p_q;
	logic act_m_q, act_s_q, act_p_q;
	logic busy_m_q, busy_s_q;

	always_ff @(posedge clk)
	begin
		wr_m_q   <= wr_tgl_q;
		wr_s_q   <= wr_m_q;
		wr_p_q   <= wr_s_q;
		rd_m_q   <= rd_req_tgl_q;
		rd_s_q   <= rd_m_q;
		rd_p_q   <= rd_s_q;
		act_m_q  <= act_tgl_q;
		act_s_q  <= act_m_q;
		act_p_q  <= act_s_q;
		busy_m_q <= busy_q;
		busy_s_q <= busy_m_q;
	end

	// ----------------------------------------------------------------
	// core domain: register access
	// ----------------------------------------------------------------
	// hold words are stable for many core cycles after the toggle flips
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			reg_req.wr_en  <= 1'b0;
			reg_req.rd_en  <= 1'b0;
			reg_req.ptr    <= smb_pkg::PTR_RESET;
			reg_req.wdata  <= smb_pkg::BYTE_RESET;
			rd_data_hold_q <= smb_pkg::BYTE_RESET;
			rd_ack_tgl_q   <= 1'b0;
		end
		else
		begin
			reg_req.wr_en <= 1'b0;
			reg_req.rd_en <= 1'b0;
			if (wr_s_q != wr_p_q)
			begin
				reg_req.ptr <= ptr_q;
				if (wr_is_data_q)
				begin
					reg_req.wdata <= wdat_q;
					reg_req.wr_en <= 1'b1;
				end
			end
			if (rd_s_q != rd_p_q)
			begin
				rd_data_hold_q <= reg_rd_data;
				reg_req.rd_en  <= 1'b1;
				rd_ack_tgl_q   <= ~rd_ack_tgl_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// core domain: inactivity watchdog
	// ----------------------------------------------------------------
	logic [31:0] idle_cnt_q;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			idle_cnt_q  <= 32'h0;
			abort_tgl_q <= 1'b0;
		end
		else if (!busy_s_q || act_s_q != act_p_q || bus_timeout_disable)
			idle_cnt_q <= 32'h0;
		else if (idle_cnt_q == 32'(TIMEOUT_CYCLES - 1))
		begin
			idle_cnt_q  <= 32'h0;
			abort_tgl_q <= ~abort_tgl_q;
		end
		else
			idle_cnt_q <= idle_cnt_q + 32'h1;
	end

	// ----------------------------------------------------------------
	// alert pin
	// ----------------------------------------------------------------
	logic alert_drv_q;

	// pending level comes from logic on clk, so no synchroniser
	always_ff @(posedge clk)
	begin
		if (srst)
			alert_drv_q <= 1'b0;
		else
			alert_drv_q <= status_unmasked_pending;
	end

	assign alert_o    = 1'b0;
	assign alert_oe_n = ~alert_drv_q;

endmodule

`default_nettype wire
